// file: ptptsu_pkg.sv
// ptptsu_pkg: constants, register map and carrier types for the
// ptp time capture unit.
// assumes one 40 MHz core clock and an APB register port.
package ptptsu_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the APB)
  // ----------------------------------------------------------------
  localparam logic [31:0]
    PTPTSU_NET_CFG_ADDR   = 32'h4003_4004,
    PTPTSU_HASH_LOW_ADDR  = 32'h4003_4080,
    PTPTSU_HASH_UP_ADDR   = 32'h4003_4084,
    PTPTSU_STATUS_ADDR    = 32'h4003_4024,
    PTPTSU_INC_FRAC_ADDR  = 32'h4003_41BC,
    PTPTSU_SEC_ADDR       = 32'h4003_41D0,
    PTPTSU_NSEC_ADDR      = 32'h4003_41D4,
    PTPTSU_ADJUST_ADDR    = 32'h4003_41D8,
    PTPTSU_INC_ADDR       = 32'h4003_41DC,
    PTPTSU_CAP_SEC_ADDR   = 32'h4003_41E0,
    PTPTSU_CAP_NSEC_ADDR  = 32'h4003_41E4,
    PTPTSU_CAP_TYPE_ADDR  = 32'h4003_41E8;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int
    PTPTSU_UNI_HASH_BIT   = 6,
    PTPTSU_MULTI_HASH_BIT = 7,
    PTPTSU_ST_CAPTURE_BIT = 0,
    PTPTSU_ST_SECOND_BIT  = 1,
    PTPTSU_ADJ_SUB_BIT    = 31;
  localparam logic [7:0]  PTPTSU_INC_RESET      = 8'h00;
  localparam logic [15:0] PTPTSU_FRAC_RESET     = 16'h0000;
  localparam logic [31:0] PTPTSU_CFG_RESET      = 32'h0000_0000;
  localparam logic [29:0] PTPTSU_NS_PER_SEC     = 30'h3B9A_CA00;

  // ----------------------------------------------------------------
  // frame layout and ptp constants
  // ----------------------------------------------------------------
  localparam logic [47:0]
    PTPTSU_DA_PTP_PRIMARY = 48'h011B_1900_0000,
    PTPTSU_DA_PTP_PEER    = 48'h0180_C200_000E;
  localparam logic [15:0]
    PTPTSU_TYPE_PTP       = 16'h88F7,
    PTPTSU_TYPE_IPV6      = 16'h86DD,
    PTPTSU_UDP_PTP_PORT   = 16'h013F;
  localparam logic [3:0]  PTPTSU_PTP_VERSION    = 4'h2;
  localparam logic [6:0]
    PTPTSU_OCT_TYPE_HI    = 7'd12,
    PTPTSU_OCT_TYPE_LO    = 7'd13,
    PTPTSU_OCT_RAW_MSG    = 7'd14,
    PTPTSU_OCT_RAW_VER    = 7'd15,
    PTPTSU_OCT_PORT_HI    = 7'd56,
    PTPTSU_OCT_PORT_LO    = 7'd57,
    PTPTSU_OCT_UDP_MSG    = 7'd62,
    PTPTSU_OCT_UDP_VER    = 7'd94,
    PTPTSU_OCT_LAST       = 7'd127;
  localparam logic [3:0]
    PTPTSU_MSG_SYNC       = 4'h0,
    PTPTSU_MSG_DELAY_REQ  = 4'h1,
    PTPTSU_MSG_PDLY_REQ   = 4'h2,
    PTPTSU_MSG_PDLY_RESP  = 4'h3;

  // result of classifying one received frame, valid the cycle after its last octet
  typedef struct packed {
    logic       done;      // one-cycle pulse at end of frame
    logic       ptpEvent;  // frame is a ptp event message
    logic [3:0] msgType;   // ptp message type
    logic       hashHit;   // destination hits the hash filter
    logic       multicast; // destination group bit
  } ptptsu_class_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } ptptsu_apb_req_t;

endpackage : ptptsu_pkg

// file: ptptsu_classifier.sv
// ptptsu_classifier: watches the receive octet stream and decides at the
// last octet whether the frame is a ptp event and whether it hits the hash.
// assumes octets arrive one per valid cycle, octet 0 is flagged by sof.
`timescale 1ns/1ps
`default_nettype none
module ptptsu_classifier
  import ptptsu_pkg::*;
(
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // octet stream
  input  wire logic          octValid,
  input  wire logic [7:0]    octData,
  input  wire logic          octSof,
  input  wire logic          octEof,
  // hash filter bits
  input  wire logic [63:0]   hashBits,
  // classification result
  output ptptsu_class_t      result
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // six-bit hash index: xor of every sixth destination bit
  function automatic logic [5:0] hashIndex(input logic [47:0] da);
    logic [5:0] idx;
    idx = 6'h00;
    for (int i = 0; i < 8; i++) begin
      idx = idx ^ da[i*6 +: 6];
    end
    return idx;
  endfunction : hashIndex

  logic [6:0]  octIdx;
  logic [47:0] dstAddr;   // octet 0 in bits 47:40
  logic [15:0] etherType;
  logic [15:0] udpPort;
  logic [3:0]  rawMsg;
  logic [3:0]  rawVer;
  logic [3:0]  udpMsg;
  logic [3:0]  udpVer;

  // index of the octet arriving now
  wire logic [6:0] curIdx = octSof ? 7'd0 : octIdx;

  // ----------------------------------------------------------------
  // octet capture
  // ----------------------------------------------------------------
  // counter saturates, later octets carry nothing we look at
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      octIdx    <= 7'd0;
      dstAddr   <= 48'h0000_0000_0000;
      etherType <= 16'h0000;
      udpPort   <= 16'h0000;
      rawMsg    <= 4'h0;
      rawVer    <= 4'h0;
      udpMsg    <= 4'h0;
      udpVer    <= 4'h0;
    end else if (octValid) begin
      if (curIdx != PTPTSU_OCT_LAST) octIdx <= curIdx + 7'd1;
      if (curIdx < 7'd6) dstAddr[47 - curIdx*8 -: 8] <= octData;
      if (curIdx == PTPTSU_OCT_TYPE_HI) etherType[15:8] <= octData; // [RULE_03]
      if (curIdx == PTPTSU_OCT_TYPE_LO) etherType[7:0]  <= octData; // [RULE_03]
      if (curIdx == PTPTSU_OCT_RAW_MSG) rawMsg <= octData[3:0];     // [RULE_03]
      if (curIdx == PTPTSU_OCT_RAW_VER) rawVer <= octData[3:0];     // [RULE_03]
      if (curIdx == PTPTSU_OCT_PORT_HI) udpPort[15:8] <= octData;   // [RULE_04]
      if (curIdx == PTPTSU_OCT_PORT_LO) udpPort[7:0]  <= octData;   // [RULE_04]
      if (curIdx == PTPTSU_OCT_UDP_MSG) udpMsg <= octData[3:0];     // [RULE_04]
      if (curIdx == PTPTSU_OCT_UDP_VER) udpVer <= octData[3:0];     // [RULE_04]
    end
  end

  // ----------------------------------------------------------------
  // decision
  // ----------------------------------------------------------------
  wire logic rawPtp = (etherType == PTPTSU_TYPE_PTP) &&
                      (rawVer == PTPTSU_PTP_VERSION);
  wire logic udpPtp = (etherType == PTPTSU_TYPE_IPV6) &&
                      (udpPort == PTPTSU_UDP_PTP_PORT) &&
                      (udpVer == PTPTSU_PTP_VERSION);
  // primary group: sync and delay request only
  wire logic primEvt = (dstAddr == PTPTSU_DA_PTP_PRIMARY) &&
                       ((rawMsg == PTPTSU_MSG_SYNC) ||
                        (rawMsg == PTPTSU_MSG_DELAY_REQ)); // [RULE_01]
  // peer group passes spanning-tree blocked ports: sync and peer delay
  wire logic peerEvt = (dstAddr == PTPTSU_DA_PTP_PEER) &&
                       ((rawMsg == PTPTSU_MSG_SYNC) ||
                        (rawMsg == PTPTSU_MSG_PDLY_REQ) ||
                        (rawMsg == PTPTSU_MSG_PDLY_RESP)); // [RULE_02]
  wire logic udpEvt  = udpPtp && (udpMsg <= PTPTSU_MSG_PDLY_RESP); // [RULE_04]
  wire logic endNow  = octValid && octEof;
  wire logic [5:0] hIdx = hashIndex(dstAddr);

  // result registered so the capture sees a clean pulse
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result <= '0;
    end else begin
      result.done      <= endNow;
      result.ptpEvent  <= endNow && ((rawPtp && (primEvt || peerEvt)) ||
                                     udpEvt);
      result.msgType   <= udpPtp ? udpMsg : rawMsg;
      result.hashHit   <= hashBits[hIdx];
      result.multicast <= dstAddr[40];
    end
  end

endmodule : ptptsu_classifier
`default_nettype wire

// file: ptptsu_top.sv
// ptptsu_top: ptp time capture unit of the gigabit mac receive path.
// assumes apb register access, one clock, receive octets synchronous.
// Operation
// RULE_01 - group 011B19000000: type 00 is sync, 01 delay request
// RULE_02 - group 0180C200000E: 00 sync, 02 peer request, 03 peer response
// RULE_03 - raw ptp: ethertype 88F7 at octets 12-13, type 14, version 15
// RULE_04 - udp over ipv6: port 013F at 56-57, type 62, version 94
// RULE_05 - event frame at timestamp point loads capture and raises interrupt
// RULE_06 - 62-bit timer: 32 bits seconds, 30 bits nanoseconds
// RULE_07 - nanoseconds wrap at one second and seconds increment
// RULE_08 - interrupt on every seconds increment
// RULE_09 - software reads, writes and adjusts the timer over apb
// RULE_10 - each clock timer adds increment register bits 7:0 nanoseconds
// RULE_11 - separate 16-bit sub-nanosecond increment register
// RULE_12 - upper hash word shows filter bits 63:32, read-only
// RULE_13 - hash hits accepted only with matching unicast/multicast enable
// RULE_14 - fraction accumulator overflow adds one extra nanosecond
`timescale 1ns/1ps
`default_nettype none
module ptptsu_top
  import ptptsu_pkg::*;
#(
  parameter int INC_W  = 8,
  parameter int FRAC_W = 16
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // receive octet stream from the mac
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxSof,
  input  wire logic        rxEof,
  // hash filter upper half, kept by the mac address logic
  input  wire logic [31:0] hashUpperIn,
  // events
  output logic             captureIrq,
  output logic             secondIrq,
  output logic             frameHashAccept
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  ptptsu_apb_req_t req;
  assign req = '{psel, penable, pwrite, paddr, pwdata};

  wire logic access  = req.psel && req.penable;
  wire logic wrStb   = access && req.pwrite;
  wire logic setup   = req.psel && !req.penable;
  wire logic hitCfg  = req.paddr == PTPTSU_NET_CFG_ADDR;
  wire logic hitHl   = req.paddr == PTPTSU_HASH_LOW_ADDR;
  wire logic hitHu   = req.paddr == PTPTSU_HASH_UP_ADDR;
  wire logic hitSt   = req.paddr == PTPTSU_STATUS_ADDR;
  wire logic hitFr   = req.paddr == PTPTSU_INC_FRAC_ADDR;
  wire logic hitSec  = req.paddr == PTPTSU_SEC_ADDR;
  wire logic hitNs   = req.paddr == PTPTSU_NSEC_ADDR;
  wire logic hitAdj  = req.paddr == PTPTSU_ADJUST_ADDR;
  wire logic hitInc  = req.paddr == PTPTSU_INC_ADDR;
  wire logic hitCs   = req.paddr == PTPTSU_CAP_SEC_ADDR;
  wire logic hitCn   = req.paddr == PTPTSU_CAP_NSEC_ADDR;
  wire logic hitCt   = req.paddr == PTPTSU_CAP_TYPE_ADDR;
  wire logic mapped  = hitCfg | hitHl | hitHu | hitSt | hitFr | hitSec |
                       hitNs | hitAdj | hitInc | hitCs | hitCn | hitCt;

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [31:0]       netCfg;
  logic [31:0]       hashLow;
  logic [31:0]       hashUp;
  logic [INC_W-1:0]  timerIncrement;
  logic [FRAC_W-1:0] timerIncrementFraction;

  // upper hash word is read-only to software, refreshed from the mac
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      netCfg                 <= PTPTSU_CFG_RESET;
      hashLow                <= 32'h0000_0000;
      hashUp                 <= 32'h0000_0000;
      timerIncrement         <= INC_W'(PTPTSU_INC_RESET);
      timerIncrementFraction <= FRAC_W'(PTPTSU_FRAC_RESET);
    end else begin
      hashUp <= hashUpperIn; // [RULE_12]
      if (wrStb && hitCfg) netCfg  <= req.pwdata;
      if (wrStb && hitHl)  hashLow <= req.pwdata;
      if (wrStb && hitInc) timerIncrement <= req.pwdata[INC_W-1:0]; // [RULE_10]
      if (wrStb && hitFr)
        timerIncrementFraction <= req.pwdata[FRAC_W-1:0]; // [RULE_11]
    end
  end

  wire logic unicastHashEnable   = netCfg[PTPTSU_UNI_HASH_BIT];
  wire logic multicastHashEnable = netCfg[PTPTSU_MULTI_HASH_BIT];

  // ----------------------------------------------------------------
  // time counter
  // ----------------------------------------------------------------
  logic [31:0]       seconds;
  logic [29:0]       nanos;
  logic [FRAC_W-1:0] fracAcc;

  // fraction carry buys one extra nanosecond
  wire logic [FRAC_W:0] fracSum = {1'b0, fracAcc} +
                                  {1'b0, timerIncrementFraction};
  wire logic fracCarry = fracSum[FRAC_W]; // [RULE_14]

  wire logic [30:0] nsStep = {1'b0, nanos} + 31'(timerIncrement) +
                             31'(fracCarry); // [RULE_10]
  wire logic nsWrap = nsStep >= {1'b0, PTPTSU_NS_PER_SEC}; // [RULE_07]
  wire logic [30:0] nsWrapped = nsStep - {1'b0, PTPTSU_NS_PER_SEC};
  wire logic [29:0] next_nanosRun = nsWrap ? nsWrapped[29:0] : nsStep[29:0];

  // adjust: bit 31 selects subtract, low 30 bits the amount
  wire logic        adjSub  = req.pwdata[PTPTSU_ADJ_SUB_BIT];
  wire logic [29:0] adjAmt  = req.pwdata[29:0];
  wire logic [30:0] adjAdd  = {1'b0, nanos} + {1'b0, adjAmt};
  wire logic        adjOver = adjAdd >= {1'b0, PTPTSU_NS_PER_SEC};
  wire logic [30:0] adjAddW = adjAdd - {1'b0, PTPTSU_NS_PER_SEC};
  wire logic        adjUnder = nanos < adjAmt;
  wire logic [29:0] adjSubW = nanos + PTPTSU_NS_PER_SEC - adjAmt;
  wire logic [29:0] adjSubN = nanos - adjAmt;
  wire logic        adjStb  = wrStb && hitAdj;

  wire logic secStep = adjStb ? (!adjSub && adjOver) : nsWrap;

  // software writes and adjusts replace the free run for that cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seconds <= 32'h0000_0000;
      nanos   <= 30'h0000_0000;
      fracAcc <= '0;
    end else begin
      fracAcc <= fracSum[FRAC_W-1:0]; // [RULE_14]
      if (wrStb && hitSec) begin
        seconds <= req.pwdata; // [RULE_09]
      end else if (adjStb) begin
        if (adjSub && adjUnder) seconds <= seconds - 32'h0000_0001;
        else if (secStep)       seconds <= seconds + 32'h0000_0001;
      end else if (secStep) begin
        seconds <= seconds + 32'h0000_0001; // [RULE_07]
      end
      if (wrStb && hitNs) begin
        nanos <= req.pwdata[29:0]; // [RULE_09]
      end else if (adjStb) begin
        if (adjSub) nanos <= adjUnder ? adjSubW : adjSubN; // [RULE_09]
        else        nanos <= adjOver ? adjAddW[29:0] : adjAdd[29:0];
      end else begin
        nanos <= next_nanosRun; // [RULE_06]
      end
    end
  end

  // ----------------------------------------------------------------
  // frame classification and capture
  // ----------------------------------------------------------------
  ptptsu_class_t cls;

  ptptsu_classifier u_classifier (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .octValid (rxValid),
    .octData  (rxData),
    .octSof   (rxSof),
    .octEof   (rxEof),
    .hashBits ({hashUp, hashLow}),
    .result   (cls)
  );

  // time is taken as the first octet passes; the frame is only known
  // to be an event at its end, so the stamp waits in a holding pair
  logic [31:0] sofSec;
  logic [29:0] sofNs;
  logic [31:0] capSec;
  logic [29:0] capNs;
  logic [3:0]  capType;
  wire logic   sofStb  = rxValid && rxSof;
  wire logic   capLoad = cls.done && cls.ptpEvent;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sofSec  <= 32'h0000_0000;
      sofNs   <= 30'h0000_0000;
      capSec  <= 32'h0000_0000;
      capNs   <= 30'h0000_0000;
      capType <= 4'h0;
    end else begin
      if (sofStb) begin
        sofSec <= seconds;
        sofNs  <= nanos;
      end
      if (capLoad) begin
        capSec  <= sofSec; // [RULE_05]
        capNs   <= sofNs;  // [RULE_05]
        capType <= cls.msgType;
      end
    end
  end

  // ----------------------------------------------------------------
  // event pulses and sticky status
  // ----------------------------------------------------------------
  logic [1:0] status;
  wire logic  stClr = wrStb && hitSt;

  // a new event in the clearing cycle stays set
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      captureIrq      <= 1'b0;
      secondIrq       <= 1'b0;
      frameHashAccept <= 1'b0;
      status          <= 2'b00;
    end else begin
      captureIrq <= capLoad;  // [RULE_05]
      secondIrq  <= secStep;  // [RULE_08]
      frameHashAccept <= cls.done && cls.hashHit &&
                         (cls.multicast ? multicastHashEnable
                                        : unicastHashEnable); // [RULE_13]
      status[PTPTSU_ST_CAPTURE_BIT] <= capLoad ||
        (status[PTPTSU_ST_CAPTURE_BIT] &&
         !(stClr && req.pwdata[PTPTSU_ST_CAPTURE_BIT]));
      status[PTPTSU_ST_SECOND_BIT] <= secStep ||
        (status[PTPTSU_ST_SECOND_BIT] &&
         !(stClr && req.pwdata[PTPTSU_ST_SECOND_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // read data, registered in the setup phase
  // ----------------------------------------------------------------
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitCfg) rdMux = netCfg;
    if (hitHl)  rdMux = hashLow;
    if (hitHu)  rdMux = hashUp; // [RULE_12]
    if (hitSt)  rdMux = {30'h0000_0000, status};
    if (hitFr)  rdMux = 32'(timerIncrementFraction);
    if (hitSec) rdMux = seconds; // [RULE_09]
    if (hitNs)  rdMux = {2'b00, nanos};
    if (hitInc) rdMux = 32'(timerIncrement);
    if (hitCs)  rdMux = capSec;
    if (hitCn)  rdMux = {2'b00, capNs};
    if (hitCt)  rdMux = {28'h000_0000, capType};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) prdata <= 32'h0000_0000;
    else if (setup && !req.pwrite) prdata <= rdMux;
  end

endmodule : ptptsu_top
`default_nettype wire

// file: ptptsu_chk.sv
// ptptsu_chk: port-level assertions for ptptsu_top.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ptptsu_chk
  import ptptsu_pkg::*;
#(
  parameter int INC_W  = 8,
  parameter int FRAC_W = 16
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // receive and events
  input wire logic        rxValid,
  input wire logic        rxEof,
  input wire logic        captureIrq,
  input wire logic        secondIrq,
  input wire logic        frameHashAccept
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_ready_high: assert property (
    psel && penable |-> pready) else $error("no ready in access");
  chk_err_access: assert property (
    pslverr |-> psel && penable) else $error("error outside access");
  chk_hash_mapped: assert property (
    psel && penable && paddr == PTPTSU_HASH_UP_ADDR |-> !pslverr)
    else $error("upper hash word refused");
  // read data only moves after a read setup cycle
  chk_rdata_hold: assert property (
    !$past(psel && !penable && !pwrite) |-> $stable(prdata))
    else $error("read data moved");
  chk_cap_cause: assert property (
    captureIrq |-> $past(rxValid && rxEof, 2))
    else $error("capture without frame end");
  chk_cap_pulse: assert property (
    captureIrq |=> !captureIrq) else $error("capture pulse too long");
  chk_sec_pulse: assert property (
    $rose(secondIrq) |=> !secondIrq) else $error("second pulse too long");
  chk_hash_cause: assert property (
    frameHashAccept |-> $past(rxValid && rxEof, 2))
    else $error("hash accept without frame end");
endmodule : ptptsu_chk
bind ptptsu_top ptptsu_chk #(.INC_W(INC_W), .FRAC_W(FRAC_W)) ptptsu_chk_inst (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxValid(rxValid), .rxEof(rxEof),
  .captureIrq(captureIrq), .secondIrq(secondIrq),
  .frameHashAccept(frameHashAccept));
`default_nettype wire

// file: ptptsu_phy_model.sv
// ptptsu_phy_model: receive side of the mac, plays whole frames.
// assumes the caller's clock; one octet per cycle, no gaps in a frame.
`timescale 1ns/1ps
`default_nettype none
module ptptsu_phy_model (
  // clock
  input  wire logic       clk_sys,
  // octet stream towards the unit
  output var  logic       rxValid,
  output var  logic [7:0] rxData,
  output var  logic       rxSof,
  output var  logic       rxEof
);
  // ------------------------------------------------------------
  // frame builder
  // ------------------------------------------------------------
  initial begin
    {rxValid, rxData, rxSof, rxEof} = 11'h000;
  end
  // octet i: raw ptp at 12..15, udp over ipv6 at 56..94
  function automatic logic [7:0] octet(input int i, input logic [47:0] da,
    input logic [15:0] ety, input logic [3:0] msg);
    logic udp;
    udp = (ety == 16'h86DD);
    if (i < 6) return da[47 - 8 * i -: 8];
    if (i == 12) return ety[15:8];
    if (i == 13) return ety[7:0];
    if ((i == 14 && !udp) || (i == 62 && udp)) return {4'h0, msg};
    if ((i == 15 && !udp) || (i == 94 && udp)) return 8'h02;
    if (i == 56 && udp) return 8'h01;
    if (i == 57 && udp) return 8'h3F;
    return 8'h00;
  endfunction : octet
  // 96 octets so the udp version octet is inside the frame
  task automatic send(input logic [47:0] da, input logic [15:0] ety,
    input logic [3:0] msg);
    for (int i = 0; i < 96; i++) begin
      @(posedge clk_sys);
      #1;
      rxValid = 1'b1;
      rxSof = (i == 0);
      rxEof = (i == 95);
      rxData = octet(i, da, ety, msg);
    end
    @(posedge clk_sys);
    #1;
    rxValid = 1'b0;
    rxEof = 1'b0;
    rxData = ~rxData; // idle line shows no stale octet
  endtask : send
endmodule : ptptsu_phy_model
`default_nettype wire

// file: ptptsu_tb.sv
// testbench: self-checking bench for ptptsu_top.
// assumes ptptsu_pkg, the checker and the phy model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ptptsu_pkg::*;
;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, hashUpperIn, rd;
  logic        rxValid, rxSof, rxEof, captureIrq, secondIrq, frameHashAccept;
  logic [7:0]  rxData;
  int          fail_count = 0, tests_run = 0;
  int          capCount = 0, hashCount = 0, secCount = 0;
  // ------------------------------------------------------------
  // design, far side and clock
  // ------------------------------------------------------------
  ptptsu_top ptptsu_top_inst (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxValid(rxValid),
    .rxData(rxData), .rxSof(rxSof), .rxEof(rxEof),
    .hashUpperIn(hashUpperIn), .captureIrq(captureIrq),
    .secondIrq(secondIrq), .frameHashAccept(frameHashAccept));
  ptptsu_phy_model ptptsu_phy_model_inst (.clk_sys(clk_sys),
    .rxValid(rxValid), .rxData(rxData), .rxSof(rxSof), .rxEof(rxEof));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // pulse counters; scenarios compare them before and after
  always @(posedge clk_sys) begin
    capCount += int'(captureIrq);
    hashCount += int'(frameHashAccept);
    secCount += int'(secondIrq);
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic print_verdict;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // one apb transfer; answer taken at the access edge
  task automatic apb(input logic w, input logic [31:0] a,
    input logic [31:0] d = '0);
    @(posedge clk_sys);
    #1;
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(posedge clk_sys);
    #1;
    penable = 1'b1;
    @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    #1;
    psel = 1'b0;
    penable = 1'b0;
  endtask : apb
  task automatic test_regs;
    hashUpperIn = 32'h1357_9BDF;
    apb(1'b1, PTPTSU_HASH_UP_ADDR);
    apb(1'b0, PTPTSU_HASH_UP_ADDR);
    chk_word(rd, 32'h1357_9BDF);
    chk_word({31'h0, err}, 32'h0000_0000);
    apb(1'b0, 32'h4003_4FF0);
    chk_word({31'h0, err}, 32'h0000_0001);
    $display("test_regs done");
  endtask : test_regs
  // wrap just below one second, then step and fraction checks
  task automatic test_timer;
    int n;
    apb(1'b1, PTPTSU_SEC_ADDR, 32'h0000_0005);
    apb(1'b1, PTPTSU_NSEC_ADDR, 32'h3B9A_C9CE);
    apb(1'b1, PTPTSU_INC_ADDR, 32'h0000_0064);
    n = secCount;
    for (int i = 0; i < 20 && secCount == n; i++) @(posedge clk_sys);
    chk_word(secCount - n, 32'h0000_0001);
    if (secCount == n) print_verdict;
    apb(1'b1, PTPTSU_INC_ADDR);
    apb(1'b0, PTPTSU_SEC_ADDR);
    chk_word(rd, 32'h0000_0006);
    apb(1'b0, PTPTSU_NSEC_ADDR);
    chk_word(rd % 100, 32'h0000_0032);
    apb(1'b1, PTPTSU_NSEC_ADDR);
    apb(1'b1, PTPTSU_INC_ADDR, 32'h0000_0003);
    repeat (100) @(posedge clk_sys);
    apb(1'b1, PTPTSU_INC_ADDR);
    apb(1'b0, PTPTSU_NSEC_ADDR);
    chk_word(32'(rd % 3 == 0 && rd >= 300 && rd <= 312), 1);
    apb(1'b1, PTPTSU_NSEC_ADDR);
    apb(1'b1, PTPTSU_INC_FRAC_ADDR, 32'h0000_8000);
    repeat (200) @(posedge clk_sys);
    apb(1'b1, PTPTSU_INC_FRAC_ADDR);
    apb(1'b0, PTPTSU_NSEC_ADDR);
    chk_word(32'(rd >= 99 && rd <= 102), 1);
    apb(1'b1, PTPTSU_NSEC_ADDR, 32'h0000_03E8);
    apb(1'b1, PTPTSU_ADJUST_ADDR, 32'h8000_0190);
    apb(1'b0, PTPTSU_NSEC_ADDR);
    chk_word(rd, 32'h0000_0258);
    $display("test_timer done");
  endtask : test_timer
  // timer is frozen at 600 ns, so the capture is exact
  task automatic check_frame(input logic [47:0] da, input logic [15:0] ety,
    input logic [3:0] msg, input logic ev);
    int n;
    n = capCount;
    ptptsu_phy_model_inst.send(da, ety, msg);
    repeat (4) @(posedge clk_sys);
    #1;
    chk_word(capCount - n, {31'h0, ev});
    if (ev) begin
      apb(1'b0, PTPTSU_CAP_TYPE_ADDR);
      chk_word(rd, {28'h0, msg});
      apb(1'b0, PTPTSU_CAP_NSEC_ADDR);
      chk_word(rd, 32'h0000_0258);
    end
  endtask : check_frame
  task automatic check_hash(input logic [31:0] cfg, input logic [47:0] da,
    input logic ev);
    int n;
    n = hashCount;
    apb(1'b1, PTPTSU_NET_CFG_ADDR, cfg);
    ptptsu_phy_model_inst.send(da, 16'h0800, 4'h0);
    repeat (4) @(posedge clk_sys);
    #1;
    chk_word(hashCount - n, {31'h0, ev});
  endtask : check_hash
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, hashUpperIn} = {3'b100, 97'h0};
    repeat (8) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    test_regs;
    test_timer;
    check_frame(48'h011B_1900_0000, 16'h88F7, 4'h0, 1'b1);
    check_frame(48'h011B_1900_0000, 16'h88F7, 4'h1, 1'b1);
    check_frame(48'h011B_1900_0000, 16'h88F7, 4'h2, 1'b0);
    check_frame(48'h0180_C200_000E, 16'h88F7, 4'h0, 1'b1);
    check_frame(48'h0180_C200_000E, 16'h88F7, 4'h2, 1'b1);
    check_frame(48'h0180_C200_000E, 16'h88F7, 4'h3, 1'b1);
    check_frame(48'h011B_1900_0000, 16'h0800, 4'h0, 1'b0);
    check_frame(48'h0200_0000_0001, 16'h86DD, 4'h3, 1'b1);
    $display("test_frames done");
    hashUpperIn = 32'hFFFF_FFFF;
    apb(1'b1, PTPTSU_HASH_LOW_ADDR, 32'hFFFF_FFFF);
    check_hash(32'h0000_0000, 48'h011B_1900_0000, 1'b0);
    check_hash(32'h0000_0080, 48'h011B_1900_0000, 1'b1);
    check_hash(32'h0000_0040, 48'h011B_1900_0000, 1'b0);
    check_hash(32'h0000_0040, 48'h0200_0000_0001, 1'b1);
    check_hash(32'h0000_0080, 48'h0200_0000_0001, 1'b0);
    $display("test_hash done");
    print_verdict;
  end
  initial begin
    #1_500_000;
    fail_count++;
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
